// file: inc/fctc_defines.svh
`ifndef FCTC_DEFINES_SVH
`define FCTC_DEFINES_SVH

// Register pointer values
`define FCTC_REG_FLASH_CUR 8'hb0
`define FCTC_REG_TMO_ILIM 8'hc0

// Reset contents
`define FCTC_RST_FLASH_CUR 8'hdd
`define FCTC_RST_TMO_ILIM 7'h6f

// Field layout
`define FCTC_LED1_LSB 0
`define FCTC_LED2_LSB 4
`define FCTC_LED_W 4
`define FCTC_TMO_LSB 0
`define FCTC_TMO_W 5
`define FCTC_ILIM_LSB 5
`define FCTC_ILIM_W 2
`define FCTC_DUR_USED_W 7

// Current step of one source, in microamps
`define FCTC_I_STEP_UA 56250
// Steps of one source at a given code: code plus one
`define FCTC_STEP_OFFSET 5'h01

// Peak switch current limits, in units of 100 mA
`define FCTC_ILIM_CODE0 6'h0e
`define FCTC_ILIM_CODE1 6'h15
`define FCTC_ILIM_CODE2 6'h1b
`define FCTC_ILIM_CODE3 6'h20

// Flash timeout granularity
`define FCTC_TMO_STEP_MS 32
`define FCTC_CLK_HZ 20000000
`define FCTC_TMO_STEP_CYC ((`FCTC_TMO_STEP_MS * `FCTC_CLK_HZ) / 1000)
`define FCTC_TMO_CYC_W 25

// Serial framing
`define FCTC_BYTE_BITS 4'h8
`define FCTC_ADDR_DEFAULT 7'h53

`endif

// file: inc/fctc_pkg.sv
`include "fctc_defines.svh"

package fctc_pkg;

	// Serial slave sequencing
	typedef enum logic [3:0] {
		FCTC_IDLE,
		FCTC_ADDR,
		FCTC_ADDR_ACK,
		FCTC_PTR,
		FCTC_PTR_ACK,
		FCTC_WDATA,
		FCTC_WDATA_ACK,
		FCTC_RDATA,
		FCTC_RDATA_ACK
	} fctc_state_t;

	// Number of 56.25 mA steps delivered by one source for a code
	function automatic logic [4:0] fctc_steps(input logic [3:0] code);
		fctc_steps = {1'b0, code} + `FCTC_STEP_OFFSET;
	endfunction : fctc_steps

endpackage : fctc_pkg

// file: rtl/fctc_line_watch.sv
`timescale 1ns/100ps

// Watches the two serial lines and flags clock edges and bus conditions
module fctc_line_watch (
	input wire logic core_clk, // System clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic scl, // Serial clock level
	input wire logic sda_in, // Serial data level
	output logic scl_rise, // Serial clock went high
	output logic scl_fall, // Serial clock went low
	output logic start_seen, // Data fell while clock high
	output logic stop_seen // Data rose while clock high
);
	logic scl_prev; // Clock level one cycle ago
	logic sda_prev; // Data level one cycle ago

	// Idle bus is high on both lines, so reset to high avoids a false clock rise or stop
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda_in;
		end
	end

	// Edge and condition decode
	always_comb begin
		scl_rise = scl & ~scl_prev;
		scl_fall = ~scl & scl_prev;
		start_seen = scl & scl_prev & sda_prev & ~sda_in;
		stop_seen = scl & scl_prev & ~sda_prev & sda_in;
	end

endmodule : fctc_line_watch

// file: rtl/fctc_config.sv
`timescale 1ns/100ps
`include "fctc_defines.svh"

module fctc_config
	import fctc_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = `FCTC_ADDR_DEFAULT, // Serial slave address
	parameter int unsigned TMO_STEP_CYCLES = `FCTC_TMO_STEP_CYC // Cycles per 32 ms step
) (
	input wire logic core_clk, // System clock, 20 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic scl, // Serial clock from host
	input wire logic sda_in, // Serial data level seen on pin
	output logic sda_out, // Serial data drive value, always low
	output logic sda_oe, // High while pulling data low
	output logic [3:0] led1_flash_code, // LED1 flash current select
	output logic [3:0] led2_flash_code, // LED2 flash current select
	output logic [4:0] led1_flash_steps, // LED1 current in 56.25 mA steps
	output logic [4:0] led2_flash_steps, // LED2 current in 56.25 mA steps
	output logic [5:0] total_flash_steps, // Combined current in 56.25 mA steps
	output logic [4:0] timeout_sel, // Flash timeout select
	output logic [`FCTC_TMO_CYC_W-1:0] timeout_cycles, // Flash timeout in clock cycles
	output logic [1:0] ilim_sel, // Switch current limit select
	output logic [5:0] ilim_deciamps // Switch peak limit in 100 mA units
);
	logic scl_rise; // Sample point for incoming bits
	logic scl_fall; // Change point for outgoing bits
	logic start_seen; // Start or repeated start
	logic stop_seen; // Stop

	fctc_state_t state, next_state; // Slave sequencer
	logic [3:0] bit_cnt, next_bit_cnt; // Bits moved in current byte
	logic [7:0] shreg, next_shreg; // Byte shifter
	logic [7:0] ptr, next_ptr; // Register pointer
	logic rw, next_rw; // High for a read transfer
	logic next_sda_oe; // Data pull-down
	logic [7:0] flash_current_select, next_flash_current_select; // Both LED current codes
	logic [6:0] flash_timeout_and_current_limit, next_flash_timeout_and_current_limit; // Timeout and limit
	logic [7:0] rd_byte; // Byte presented on a read
	logic [4:0] next_led1_steps, next_led2_steps; // Decoded step counts
	logic [5:0] next_total_steps; // Combined step count
	logic [`FCTC_TMO_CYC_W-1:0] next_timeout_cycles; // Decoded timeout
	logic [5:0] next_ilim_deciamps; // Decoded limit

	fctc_line_watch u_line_watch (
		.core_clk(core_clk),
		.rstn(rstn),
		.scl(scl),
		.sda_in(sda_in),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	// Read mux; the unused top bit of the duration register reads zero
	always_comb begin
		unique case (ptr)
			`FCTC_REG_FLASH_CUR: rd_byte = flash_current_select;
			`FCTC_REG_TMO_ILIM: rd_byte = {1'b0, flash_timeout_and_current_limit};
			default: rd_byte = 8'h00;
		endcase
	end

	// Serial slave and register writes
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_ptr = ptr;
		next_rw = rw;
		next_sda_oe = sda_oe;
		next_flash_current_select = flash_current_select;
		next_flash_timeout_and_current_limit = flash_timeout_and_current_limit;
		if (stop_seen) begin
			// Stop always frees the bus
			next_state = FCTC_IDLE;
			next_sda_oe = 1'b0;
		end else if (start_seen) begin
			// A repeated start restarts address reception, pointer kept
			next_state = FCTC_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			unique case (state)
				FCTC_ADDR, FCTC_PTR, FCTC_WDATA: begin
					// Incoming bits arrive MSB first
					next_shreg = {shreg[6:0], sda_in};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				FCTC_RDATA: begin
					next_bit_cnt = bit_cnt + 4'h1;
				end
				FCTC_RDATA_ACK: begin
					// Host not acknowledging ends the read
					if (sda_in) begin
						next_state = FCTC_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (state)
				FCTC_ADDR: begin
					if (bit_cnt == `FCTC_BYTE_BITS) begin
						if (shreg[7:1] == SLAVE_ADDR) begin
							next_sda_oe = 1'b1;
							next_rw = shreg[0];
							next_state = FCTC_ADDR_ACK;
						end else begin
							// Another device is addressed; stay off the bus
							next_state = FCTC_IDLE;
						end
					end
				end
				FCTC_ADDR_ACK, FCTC_RDATA_ACK: begin
					next_bit_cnt = 4'h0;
					if (rw) begin
						// Present the first bit of the byte, MSB first
						next_shreg = rd_byte;
						next_sda_oe = ~rd_byte[7];
						next_state = FCTC_RDATA;
					end else begin
						next_sda_oe = 1'b0;
						next_state = FCTC_PTR;
					end
				end
				FCTC_PTR: begin
					if (bit_cnt == `FCTC_BYTE_BITS) begin
						next_ptr = shreg;
						next_sda_oe = 1'b1;
						next_state = FCTC_PTR_ACK;
					end
				end
				FCTC_PTR_ACK, FCTC_WDATA_ACK: begin
					next_sda_oe = 1'b0;
					next_bit_cnt = 4'h0;
					next_state = FCTC_WDATA;
				end
				FCTC_WDATA: begin
					if (bit_cnt == `FCTC_BYTE_BITS) begin
						// Whole byte only; unknown pointers are acked but dropped
						if (ptr == `FCTC_REG_FLASH_CUR) begin
							next_flash_current_select = shreg;
						end
						if (ptr == `FCTC_REG_TMO_ILIM) begin
							next_flash_timeout_and_current_limit = shreg[`FCTC_DUR_USED_W-1:0];
						end
						next_ptr = ptr + 8'h01;
						next_sda_oe = 1'b1;
						next_state = FCTC_WDATA_ACK;
					end
				end
				FCTC_RDATA: begin
					if (bit_cnt == `FCTC_BYTE_BITS) begin
						// Release for the host acknowledge, then move on
						next_sda_oe = 1'b0;
						next_ptr = ptr + 8'h01;
						next_state = FCTC_RDATA_ACK;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = ~shreg[6];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Slave and register state
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= FCTC_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			sda_oe <= 1'b0;
			flash_current_select <= `FCTC_RST_FLASH_CUR;
			flash_timeout_and_current_limit <= `FCTC_RST_TMO_ILIM;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			ptr <= next_ptr;
			rw <= next_rw;
			sda_oe <= next_sda_oe;
			flash_current_select <= next_flash_current_select;
			flash_timeout_and_current_limit <= next_flash_timeout_and_current_limit;
		end
	end

	// Field decode toward the analog side; registered so outputs never glitch
	always_comb begin
		next_led1_steps = fctc_steps(flash_current_select[`FCTC_LED1_LSB +: `FCTC_LED_W]);
		next_led2_steps = fctc_steps(flash_current_select[`FCTC_LED2_LSB +: `FCTC_LED_W]);
		next_total_steps = {1'b0, next_led1_steps} + {1'b0, next_led2_steps};
		// Product stays under 2^25 for every code at the default step
		next_timeout_cycles = `FCTC_TMO_CYC_W'((32'(flash_timeout_and_current_limit[`FCTC_TMO_LSB +: `FCTC_TMO_W])
			+ 32'd1) * TMO_STEP_CYCLES);
		unique case (flash_timeout_and_current_limit[`FCTC_ILIM_LSB +: `FCTC_ILIM_W])
			2'b00: next_ilim_deciamps = `FCTC_ILIM_CODE0;
			2'b01: next_ilim_deciamps = `FCTC_ILIM_CODE1;
			2'b10: next_ilim_deciamps = `FCTC_ILIM_CODE2;
			2'b11: next_ilim_deciamps = `FCTC_ILIM_CODE3;
		endcase
	end

	// Decoded outputs; they lag the register by one cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			led1_flash_steps <= 5'h00;
			led2_flash_steps <= 5'h00;
			total_flash_steps <= 6'h00;
			timeout_cycles <= '0;
			ilim_deciamps <= 6'h00;
		end else begin
			led1_flash_steps <= next_led1_steps;
			led2_flash_steps <= next_led2_steps;
			total_flash_steps <= next_total_steps;
			timeout_cycles <= next_timeout_cycles;
			ilim_deciamps <= next_ilim_deciamps;
		end
	end

	// Raw fields straight from the register flops; data drive value tied low
	always_comb begin
		sda_out = 1'b0;
		led1_flash_code = flash_current_select[`FCTC_LED1_LSB +: `FCTC_LED_W];
		led2_flash_code = flash_current_select[`FCTC_LED2_LSB +: `FCTC_LED_W];
		timeout_sel = flash_timeout_and_current_limit[`FCTC_TMO_LSB +: `FCTC_TMO_W];
		ilim_sel = flash_timeout_and_current_limit[`FCTC_ILIM_LSB +: `FCTC_ILIM_W];
	end

endmodule : fctc_config

// file: sim/fctc_host.sv
`timescale 1ns/100ps
`include "fctc_defines.svh"

// Host controller model; its clock stands high outside frames
module fctc_host (
	input wire logic core_clk, // System clock
	input wire logic sda, // Resolved data wire
	output logic scl, // Serial clock
	output logic sda_h // Host data drive, 1 releases
);
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// Data moves only while the clock is low, sampled mid high phase
	task automatic put_bit(input logic b, output logic got);
		sda_h <= b;
		tick(4);
		scl <= 1'b1;
		tick(3);
		@(negedge core_clk);
		got = sda;
		tick(5);
		scl <= 1'b0;
		tick(4);
	endtask : put_bit
	// Eight bits then the acknowledge slot
	task automatic put_byte(input logic [7:0] v, input logic a, output logic [7:0] rd, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(v[i], g);
			rd[i] = g;
		end
		put_bit(a, ack);
	endtask : put_byte
	task automatic start();
		sda_h <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_h <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask : start
	task automatic stop();
		sda_h <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_h <= 1'b1;
		tick(8);
	endtask : stop
	// Address byte alone, then stop; hands back the acknowledge level seen
	task automatic probe(input logic [6:0] addr, output logic ack);
		logic [7:0] r;
		start();
		put_byte({addr, 1'b0}, 1'b1, r, ack);
		stop();
	endtask : probe
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start();
		put_byte({`FCTC_ADDR_DEFAULT, 1'b0}, 1'b1, r, a0);
		put_byte(ptr, 1'b1, r, a1);
		put_byte(d, 1'b1, r, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask : write_reg
	// Single byte read, closed by a refusal of the host
	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		start();
		put_byte({`FCTC_ADDR_DEFAULT, 1'b0}, 1'b1, r, a0);
		put_byte(ptr, 1'b1, r, a1);
		start();
		put_byte({`FCTC_ADDR_DEFAULT, 1'b1}, 1'b1, r, a2);
		put_byte(8'hff, 1'b1, d, a3);
		stop();
		ok = !(a0 | a1 | a2);
	endtask : read_reg
endmodule : fctc_host

// file: sim/fctc_config_sva.sv
`timescale 1ns/100ps

// Checks decoded outputs and serial drive of the config block
module fctc_config_chk #(
	parameter int unsigned TMO_STEP_CYCLES = 10 // Cycles per step
) (
	input wire logic core_clk, // Clock
	input wire logic rstn, // Reset, active low
	input wire logic scl, // Serial clock
	input wire logic sda_in, // Data wire
	input wire logic sda_out, // Drive value
	input wire logic sda_oe, // Pull enable
	input wire logic [3:0] led1_flash_code, // LED1 code
	input wire logic [3:0] led2_flash_code, // LED2 code
	input wire logic [4:0] led1_flash_steps, // LED1 steps
	input wire logic [4:0] led2_flash_steps, // LED2 steps
	input wire logic [5:0] total_flash_steps, // Sum
	input wire logic [4:0] timeout_sel, // Timeout code
	input wire logic [24:0] timeout_cycles, // Timeout length
	input wire logic [1:0] ilim_sel, // Limit code
	input wire logic [5:0] ilim_deciamps // Limit, 100 mA
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Decodes lag by one cycle, so the first edge after reset is skipped
	sequence s_run;
		rstn && $past(rstn);
	endsequence
	// Serial clock idle long enough for any update to have landed
	sequence s_quiet;
		$stable(scl)[*6];
	endsequence
	function automatic logic [5:0] lim(input logic [1:0] c);
		case (c)
			2'h0: lim = 6'h0e; // 1.4 A
			2'h1: lim = 6'h15; // 2.1 A
			2'h2: lim = 6'h1b; // 2.7 A
			default: lim = 6'h20; // 3.2 A
		endcase
	endfunction : lim
	AST_STEPS: assert property (s_run |-> led1_flash_steps == {1'b0, $past(led1_flash_code)} + 5'h01
		&& led2_flash_steps == {1'b0, $past(led2_flash_code)} + 5'h01) else $error("step count wrong");
	AST_TOP: assert property ((led1_flash_code == 4'hf && led2_flash_code == 4'hf)[*3]
		|-> total_flash_steps == 6'h20) else $error("top total wrong");
	AST_TMO: assert property (s_run |-> timeout_cycles ==
		(25'($past(timeout_sel)) + 25'h0000001) * 25'(TMO_STEP_CYCLES)) else $error("timeout wrong");
	AST_ILIM: assert property (s_run |-> ilim_deciamps == lim($past(ilim_sel)))
		else $error("limit wrong");
	AST_HOLD: assert property (s_quiet |-> $stable({led2_flash_code, led1_flash_code, ilim_sel, timeout_sel}))
		else $error("fields moved");
	AST_OE_LOW: assert property ($rose(sda_oe) |-> !scl && !$past(scl))
		else $error("data pulled in clock high");
	AST_DRIVE0: assert property (sda_out == 1'b0)
		else $error("drive value not low");
	AST_DEF: assert property ($rose(rstn) |-> ilim_sel == 2'h3 && timeout_sel == 5'h0f)
		else $error("defaults wrong");
endmodule : fctc_config_chk

bind fctc_config fctc_config_chk #(.TMO_STEP_CYCLES(TMO_STEP_CYCLES)) chk_u (.core_clk(core_clk), .rstn(rstn),
	.scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .led1_flash_code(led1_flash_code),
	.led2_flash_code(led2_flash_code), .led1_flash_steps(led1_flash_steps), .led2_flash_steps(led2_flash_steps),
	.total_flash_steps(total_flash_steps), .timeout_sel(timeout_sel), .timeout_cycles(timeout_cycles),
	.ilim_sel(ilim_sel), .ilim_deciamps(ilim_deciamps));

// file: sim/flash_current_timeout_config_bench.sv
`timescale 1ns/100ps
`include "fctc_defines.svh"

module flash_current_timeout_config_bench;
	localparam int unsigned STEP = 10; // Short step keeps runs brief
	localparam logic [5:0] LIMS [4] = '{6'h0e, 6'h15, 6'h1b, 6'h20}; // 1.4 to 3.2 A
	localparam logic [7:0] CUR [5] = '{8'h0f, 8'hf0, 8'hff, 8'h00, 8'h5a}; // Nibble edges
	localparam logic [4:0] TMO [4] = '{5'h00, 5'h01, 5'h1f, 5'h0a}; // Code edges
	logic core_clk = 1'b0; // Clock
	logic rstn = 1'b0; // Reset, active low
	logic scl, sda_h, sda, sda_out, sda_oe; // Serial lines
	logic [3:0] led1_flash_code, led2_flash_code; // Codes
	logic [4:0] led1_flash_steps, led2_flash_steps, timeout_sel; // Decodes
	logic [5:0] total_flash_steps, ilim_deciamps; // Decodes
	logic [24:0] timeout_cycles; // Timeout length
	logic [1:0] ilim_sel; // Limit code
	int err_total = 0; // Mismatches
	int cmp_count = 0; // Comparisons
	always #25 core_clk = ~core_clk;
	assign sda = sda_oe ? 1'b0 : sda_h; // Pull-up when nobody pulls
	fctc_config #(.TMO_STEP_CYCLES(STEP)) dut_u (.core_clk(core_clk), .rstn(rstn), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .led1_flash_code(led1_flash_code), .led2_flash_code(led2_flash_code),
		.led1_flash_steps(led1_flash_steps), .led2_flash_steps(led2_flash_steps),
		.total_flash_steps(total_flash_steps), .timeout_sel(timeout_sel), .timeout_cycles(timeout_cycles),
		.ilim_sel(ilim_sel), .ilim_deciamps(ilim_deciamps));
	fctc_host host_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_h(sda_h));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic ok;
		host_u.write_reg(ptr, d, ok);
		chk("write ack", ok, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		host_u.read_reg(ptr, d, ok);
		chk("read ack", ok, 1'b1);
		chk("read data", d, exp);
	endtask : rd
	task automatic see_cur(input logic [3:0] c1, input logic [3:0] c2);
		chk("led1 code", led1_flash_code, c1);
		chk("led2 code", led2_flash_code, c2);
		chk("led1 steps", led1_flash_steps, 32'(c1) + 32'h1);
		chk("led2 steps", led2_flash_steps, 32'(c2) + 32'h1);
		chk("total steps", total_flash_steps, 32'(c1) + 32'(c2) + 32'h2);
	endtask : see_cur
	task automatic see_dur(input logic [4:0] t, input logic [1:0] l);
		chk("timeout code", timeout_sel, t);
		chk("timeout cycles", timeout_cycles, (32'(t) + 32'h1) * STEP);
		chk("limit code", ilim_sel, l);
		chk("limit", ilim_deciamps, LIMS[l]);
	endtask : see_dur
	// Defaults, nibble edges, every limit code, refusals, then a reset mid-run
	initial begin
		logic nak; // Acknowledge level for a foreign address
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		see_cur(4'hd, 4'hd);
		see_dur(5'h0f, 2'h3);
		rd(`FCTC_REG_FLASH_CUR, 8'hdd);
		rd(`FCTC_REG_TMO_ILIM, 8'h6f);
		foreach (CUR[i]) begin
			wr(`FCTC_REG_FLASH_CUR, CUR[i]);
			see_cur(CUR[i][3:0], CUR[i][7:4]);
			rd(`FCTC_REG_FLASH_CUR, CUR[i]);
		end
		for (int l = 0; l < 4; l++) begin
			wr(`FCTC_REG_TMO_ILIM, {1'b1, 2'(l), TMO[l]});
			see_dur(TMO[l], 2'(l));
			rd(`FCTC_REG_TMO_ILIM, {1'b0, 2'(l), TMO[l]});
		end
		// Another slave address must stay unanswered
		host_u.probe(`FCTC_ADDR_DEFAULT ^ 7'h01, nak);
		chk("foreign address ack", nak, 1'b1);
		// Unknown pointer is acked, its data dropped, and it reads zero
		wr(8'hb1, 8'h33);
		rd(8'hb1, 8'h00);
		see_cur(4'ha, 4'h5);
		see_dur(5'h0a, 2'h3);
		chk("drive value", sda_out, 1'b0);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		see_cur(4'hd, 4'hd);
		see_dur(5'h0f, 2'h3);
		give_verdict();
	end
	// Bounded run; running out counts as a mismatch
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		give_verdict();
	end
endmodule : flash_current_timeout_config_bench
